//--- oic_chan.sv
`timescale 1ns/1ps
module oic_chan
  import oic_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire oic_chan_cfg_t i_cfg,
  input wire logic i_permit,
  input wire logic i_release,
  output logic o_block,
  output logic o_latched
);

  typedef struct packed {
    logic latched;
  } oic_chan_state_t;

  oic_chan_state_t st_q;
  oic_chan_state_t st_d;
  logic release_now;

  // Release needs an on command while the input permits again
  assign release_now = i_release && i_permit;

  // Latch update; set and release cannot coincide since they need opposite permit
  always_comb begin
    st_d = st_q;
    if (!i_cfg.func_en || !i_cfg.latch_en) begin
      st_d.latched = OIC_RST_BIT;
    end else if (!i_permit) begin
      st_d.latched = 1'h1;
    end else if (release_now) begin
      st_d.latched = OIC_RST_BIT;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      st_q.latched <= OIC_RST_BIT;
    end else begin
      st_q <= st_d;
    end
  end

  // Disabled function never blocks; held latch blocks until released
  assign o_block = i_cfg.func_en && (!i_permit || (st_q.latched && !release_now));
  assign o_latched = st_q.latched;

endmodule : oic_chan

//--- oic_mode.sv
`timescale 1ns/1ps
module oic_mode
  import oic_pkg::*;
#(
  parameter int NPHASE = OIC_NPHASE_DEF
) (
  input wire logic i_output_on,
  input wire logic [NPHASE-1:0] i_phase_en,
  input wire logic [NPHASE-1:0] i_phase_cc,
  output logic [1:0] o_mode
);

  logic any_cc;

  // Any enabled phase in current regulation makes the whole unit CC
  assign any_cc = |(i_phase_en & i_phase_cc);

  // Off wins over any regulation state
  always_comb begin
    if (!i_output_on) begin
      o_mode = OIC_MODE_OFF;
    end else if (any_cc) begin
      o_mode = OIC_MODE_CC;
    end else begin
      o_mode = OIC_MODE_CV;
    end
  end

endmodule : oic_mode

//--- oic_monitor.sv
`timescale 1ns/1ps
module oic_monitor
  import oic_pkg::*;
#(
  parameter int NPHASE = OIC_NPHASE_DEF
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire oic_cmd_t i_cmd,
  input wire oic_chan_cfg_t i_ena_cfg,
  input wire logic i_polarity_active_high,
  input wire oic_chan_cfg_t i_estop_cfg,
  input wire oic_chan_cfg_t i_ilc_cfg,
  input wire logic i_pon_auto,
  input wire logic i_ext_enable_input,
  input wire logic i_estop_input,
  input wire logic i_interlock_input,
  input wire logic [NPHASE-1:0] i_phase_en,
  input wire logic [NPHASE-1:0] i_phase_cc,
  input wire logic o_output_on,
  input wire logic o_output_setting,
  input wire logic [1:0] o_mode,
  input wire logic o_cmd_refused,
  input wire logic o_shutdown
);
  // All checks on the system clock, quiet in reset
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  mode_off_a: assert property (!o_output_on |-> o_mode == OIC_MODE_OFF)
    else $error("mode not off with output off");
  mode_code_a: assert property (o_output_on |->
    o_mode == ((|($past(i_phase_en) & $past(i_phase_cc))) ? OIC_MODE_CC : OIC_MODE_CV))
    else $error("mode code does not follow the phases");
  stop_off_a: assert property (i_estop_cfg.func_en && i_estop_input
    |=> !o_output_on) else $error("stop did not force output off");
  ilc_off_a: assert property (i_ilc_cfg.func_en && i_interlock_input
    |=> !o_output_on) else $error("open interlock left output on");
  ena_off_a: assert property (i_ena_cfg.func_en &&
    i_ext_enable_input != i_polarity_active_high |=> !o_output_on)
    else $error("enable pin did not inhibit output");
  refuse_pulse_a: assert property (o_cmd_refused |->
    $past(i_cmd.out_on) && !o_output_on) else $error("refusal without on command");
  shut_pulse_a: assert property (o_shutdown |->
    $past(o_output_on) && !o_output_on) else $error("shutdown pulse while not leaving on");
  on_restart_a: assert property ($rose(o_output_on) |-> $past(i_cmd.out_on) ||
    ($past(i_pon_auto) && $past(o_output_setting))) else $error("output came on uncommanded");
  // Main scenarios reached
  shut_c: cover property (o_shutdown);
  refuse_c: cover property (o_cmd_refused);
  cc_mode_c: cover property (o_mode == OIC_MODE_CC);
endmodule : oic_monitor

bind oic_top oic_monitor #(.NPHASE(NPHASE)) u_mon (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_cmd(i_cmd), .i_ena_cfg(i_ena_cfg), .i_polarity_active_high(i_polarity_active_high),
  .i_estop_cfg(i_estop_cfg), .i_ilc_cfg(i_ilc_cfg), .i_pon_auto(i_pon_auto),
  .i_ext_enable_input(i_ext_enable_input), .i_estop_input(i_estop_input),
  .i_interlock_input(i_interlock_input), .i_phase_en(i_phase_en), .i_phase_cc(i_phase_cc),
  .o_output_on(o_output_on), .o_output_setting(o_output_setting), .o_mode(o_mode),
  .o_cmd_refused(o_cmd_refused), .o_shutdown(o_shutdown));

//--- oic_pkg.sv
package oic_pkg;

  // Source indices into the inhibit arrays
  localparam int OIC_NSRC = 3;
  localparam int OIC_SRC_ENA = 0;
  localparam int OIC_SRC_ESTOP = 1;
  localparam int OIC_SRC_ILC = 2;

  // Default number of power phases reported by the mode status
  localparam int OIC_NPHASE_DEF = 3;

  // Operating-mode status codes
  localparam logic [1:0] OIC_MODE_OFF = 2'h0;
  localparam logic [1:0] OIC_MODE_CV = 2'h1;
  localparam logic [1:0] OIC_MODE_CC = 2'h2;

  // Enable-input polarity selector values
  localparam logic OIC_POLARITY_ACTIVE_LOW = 1'h0;
  localparam logic OIC_POLARITY_ACTIVE_HIGH = 1'h1;

  // Level on the stop and interlock pins that asks for the output off
  localparam logic OIC_STOP_LEVEL = 1'h1;
  localparam logic OIC_ILC_OPEN_LEVEL = 1'h1;

  // Power-on recovery selector values
  localparam logic OIC_PON_SAFE = 1'h0;
  localparam logic OIC_PON_AUTO = 1'h1;

  // Reset values
  localparam logic OIC_RST_BIT = 1'h0;
  localparam logic [OIC_NSRC-1:0] OIC_RST_SRC = 3'h0;

  // Per-input configuration: function switch and latch option
  typedef struct packed {
    logic func_en;
    logic latch_en;
  } oic_chan_cfg_t;

  // Host commands, one-cycle pulses
  typedef struct packed {
    logic out_on;
    logic out_off;
  } oic_cmd_t;

  // Output sequencing states
  typedef enum logic [1:0] {
    OIC_ST_IDLE,
    OIC_ST_RUN,
    OIC_ST_HOLD
  } oic_state_t;

endpackage : oic_pkg

//--- oic_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Enable function off: enable pin level is ignored.
// - Enable latch option holds an enable-caused shutdown after the pin permits.
// - Polarity active-high permits output on high pin, active-low on low pin.
// - Stop function off: stop pin has no effect.
// - Stop function on: stop pin level forces the output off.
// - Stop latch option holds the stop shutdown after release; clear means no hold.
// - Interlock function off: interlock pin cannot disable the output.
// - Interlock function on: open interlock disables the output.
// - Interlock latch option holds the interlock shutdown after it clears.
// - Mode status shows OFF whenever the output is off.
// - Output on in voltage regulation shows the constant-voltage code.
// - Output on in current regulation shows the constant-current code.
// - Multi-phase: any enabled phase in current regulation reports constant-current.
// - After enable or interlock recovery: safe start stays off, auto restores state unless a latching input caused the shutdown.
module oic_top
  import oic_pkg::*;
#(
  parameter int NPHASE = OIC_NPHASE_DEF
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire oic_cmd_t i_cmd,
  input wire oic_chan_cfg_t i_ena_cfg,
  input wire logic i_polarity_active_high,
  input wire oic_chan_cfg_t i_estop_cfg,
  input wire oic_chan_cfg_t i_ilc_cfg,
  input wire logic i_pon_auto,
  input wire logic i_ext_enable_input,
  input wire logic i_estop_input,
  input wire logic i_interlock_input,
  input wire logic [NPHASE-1:0] i_phase_en,
  input wire logic [NPHASE-1:0] i_phase_cc,
  output logic o_output_on,
  output logic o_output_setting,
  output logic [1:0] o_mode,
  output logic [OIC_NSRC-1:0] o_blocked,
  output logic [OIC_NSRC-1:0] o_latched,
  output logic [OIC_NSRC-1:0] o_cause,
  output logic o_cmd_refused,
  output logic o_shutdown
);

  // Whole state of the block
  typedef struct packed {
    oic_state_t state;
    logic output_on;
    logic setting;
    logic [1:0] mode;
    logic [OIC_NSRC-1:0] blocked;
    logic [OIC_NSRC-1:0] latched;
    logic [OIC_NSRC-1:0] cause;
    logic refused;
    logic shutdown;
  } oic_top_state_t;

  oic_top_state_t st_q;
  oic_top_state_t st_d;

  oic_chan_cfg_t cfg [OIC_NSRC];
  logic [OIC_NSRC-1:0] permit;
  logic [OIC_NSRC-1:0] block;
  logic [OIC_NSRC-1:0] chan_latched;
  logic [OIC_NSRC-1:0] latch_cause;
  logic block_any;
  logic release_cmd;
  logic run_next;
  logic [1:0] mode_next;

  // True when a pin sits at the level that forbids the output
  function automatic logic oic_pin_forbids(input logic pin, input logic off_level);
    oic_pin_forbids = (pin == off_level);
  endfunction : oic_pin_forbids

  // Running state after this edge, worked out from the current state only, so that
  // the mode encoder never loops back through the next-state copy
  function automatic logic oic_goes_run(input oic_state_t cur, input oic_cmd_t cmd,
    input logic any_block, input logic pon_auto);
    case (cur)
      OIC_ST_IDLE: begin
        oic_goes_run = cmd.out_on && !any_block;
      end
      OIC_ST_RUN: begin
        oic_goes_run = !cmd.out_off && !any_block;
      end
      OIC_ST_HOLD: begin
        oic_goes_run = !cmd.out_off && (pon_auto == OIC_PON_AUTO) && !any_block;
      end
      default: begin
        oic_goes_run = OIC_RST_BIT;
      end
    endcase
  endfunction : oic_goes_run

  // Enable polarity picks the permitting level of the enable pin
  function automatic logic oic_ena_permits(input logic pin, input logic pol_high);
    if (pol_high == OIC_POLARITY_ACTIVE_HIGH) begin
      oic_ena_permits = pin;
    end else begin
      oic_ena_permits = !pin;
    end
  endfunction : oic_ena_permits

  // Gather the per-input configuration
  assign cfg[OIC_SRC_ENA] = i_ena_cfg;
  assign cfg[OIC_SRC_ESTOP] = i_estop_cfg;
  assign cfg[OIC_SRC_ILC] = i_ilc_cfg;

  assign permit[OIC_SRC_ENA] = oic_ena_permits(i_ext_enable_input, i_polarity_active_high);
  assign permit[OIC_SRC_ESTOP] = !oic_pin_forbids(i_estop_input, OIC_STOP_LEVEL);
  assign permit[OIC_SRC_ILC] = !oic_pin_forbids(i_interlock_input, OIC_ILC_OPEN_LEVEL);

  assign release_cmd = i_cmd.out_on;

  // One qualifier per control input; function switch and latch live inside
  genvar gi;
  generate
    for (gi = 0; gi < OIC_NSRC; gi++) begin : g_chan
      oic_chan u_chan (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_cfg(cfg[gi]),
        .i_permit(permit[gi]),
        .i_release(release_cmd),
        .o_block(block[gi]),
        .o_latched(chan_latched[gi])
      );
      // A cause that will latch cannot auto-recover
      assign latch_cause[gi] = block[gi] && cfg[gi].latch_en;
    end
  endgenerate

  assign block_any = |block;

  // Output on follows the next sequencing state
  assign run_next = oic_goes_run(st_q.state, i_cmd, block_any, i_pon_auto);

  oic_mode #(
    .NPHASE(NPHASE)
  ) u_mode (
    .i_output_on(run_next),
    .i_phase_en(i_phase_en),
    .i_phase_cc(i_phase_cc),
    .o_mode(mode_next)
  );

  // Sequencing of the output against host commands and inhibits
  always_comb begin
    st_d = st_q;
    st_d.refused = OIC_RST_BIT;
    st_d.shutdown = OIC_RST_BIT;
    case (st_q.state)
      OIC_ST_IDLE: begin
        if (i_cmd.out_on) begin
          if (block_any) begin
            st_d.refused = 1'h1;
            st_d.cause = block;
          end else begin
            st_d.state = OIC_ST_RUN;
            st_d.cause = OIC_RST_SRC;
          end
        end
      end
      OIC_ST_RUN: begin
        if (i_cmd.out_off) begin
          st_d.state = OIC_ST_IDLE;
        end else if (block_any) begin
          st_d.shutdown = 1'h1;
          st_d.cause = block;
          if ((i_pon_auto == OIC_PON_AUTO) && !block[OIC_SRC_ESTOP] && !(|latch_cause)) begin
            st_d.state = OIC_ST_HOLD;
          end else begin
            st_d.state = OIC_ST_IDLE;
          end
        end
      end
      OIC_ST_HOLD: begin
        if (i_cmd.out_off) begin
          st_d.state = OIC_ST_IDLE;
        end else if (block[OIC_SRC_ESTOP] || (i_pon_auto == OIC_PON_SAFE)) begin
          // Stop or a switch to safe start drops the remembered state
          st_d.state = OIC_ST_IDLE;
          st_d.cause = st_q.cause | block;
        end else if (!block_any) begin
          st_d.state = OIC_ST_RUN;
        end else begin
          st_d.cause = st_q.cause | block;
        end
      end
      default: begin
        st_d.state = OIC_ST_IDLE;
      end
    endcase
    st_d.output_on = run_next;
    st_d.setting = (st_d.state != OIC_ST_IDLE);
    st_d.mode = mode_next;
    st_d.blocked = block;
    st_d.latched = chan_latched;
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      st_q.state <= OIC_ST_IDLE;
      st_q.output_on <= OIC_RST_BIT;
      st_q.setting <= OIC_RST_BIT;
      st_q.mode <= OIC_MODE_OFF;
      st_q.blocked <= OIC_RST_SRC;
      st_q.latched <= OIC_RST_SRC;
      st_q.cause <= OIC_RST_SRC;
      st_q.refused <= OIC_RST_BIT;
      st_q.shutdown <= OIC_RST_BIT;
    end else begin
      st_q <= st_d;
    end
  end

  // All outputs straight from the state register
  assign o_output_on = st_q.output_on;
  assign o_output_setting = st_q.setting;
  assign o_mode = st_q.mode;
  assign o_blocked = st_q.blocked;
  assign o_latched = st_q.latched;
  assign o_cause = st_q.cause;
  assign o_cmd_refused = st_q.refused;
  assign o_shutdown = st_q.shutdown;

endmodule : oic_top

//--- oic_wiring.sv
`timescale 1ns/1ps
module oic_wiring (
  input wire logic i_mclk,
  input wire logic [2:0] i_level,
  output logic o_ext_enable_input,
  output logic o_estop_input,
  output logic o_interlock_input
);
  // Pins follow the requested levels just after each edge
  always @(posedge i_mclk) begin
    {o_interlock_input, o_estop_input, o_ext_enable_input} <= #1 i_level;
  end
endmodule : oic_wiring

//--- testbench.sv
`timescale 1ns/1ps
module testbench
  import oic_pkg::*;
;
  logic clk = 0, rst_n = 0, pol = 0, pon = 0;
  oic_cmd_t cmd = '0;
  oic_chan_cfg_t [2:0] cfg = '0;
  logic [2:0] lv = 3'h0, pen = 3'h7, pcc = 3'h0, blk, lat, cse;
  logic on, set, ref_p, shd, ena_p, stop_p, ilc_p;
  logic [1:0] mode;
  logic [31:0] rnd = 32'hB8F3;
  int errors = 0, compares = 0, cyc = 0;
  // Clock at 250 MHz
  initial begin
    forever #2 clk = ~clk;
  end
  oic_top dut (
    .i_mclk(clk), .i_reset_n(rst_n), .i_cmd(cmd), .i_ena_cfg(cfg[0]),
    .i_polarity_active_high(pol), .i_estop_cfg(cfg[1]), .i_ilc_cfg(cfg[2]),
    .i_pon_auto(pon), .i_ext_enable_input(ena_p), .i_estop_input(stop_p),
    .i_interlock_input(ilc_p), .i_phase_en(pen), .i_phase_cc(pcc),
    .o_output_on(on), .o_output_setting(set), .o_mode(mode), .o_blocked(blk),
    .o_latched(lat), .o_cause(cse), .o_cmd_refused(ref_p), .o_shutdown(shd)
  );
  oic_wiring wiring (.i_mclk(clk), .i_level(lv), .o_ext_enable_input(ena_p),
    .o_estop_input(stop_p), .o_interlock_input(ilc_p));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [1:0] exp_mode(logic [2:0] e, logic [2:0] c);
    return (|(e & c)) ? OIC_MODE_CC : OIC_MODE_CV;
  endfunction : exp_mode
  // Pin level that asks for the output off
  function automatic logic bad_lvl(int s, logic p);
    return (s == OIC_SRC_ENA) ? !p : (s == OIC_SRC_ESTOP) ? OIC_STOP_LEVEL : OIC_ILC_OPEN_LEVEL;
  endfunction : bad_lvl
  task automatic tick(int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick
  task automatic chk_bit(string nm, logic e, logic g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_mode(logic [1:0] e, logic [1:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value mode expected %h seen %h", e, g);
    end
  endtask : chk_mode
  task automatic chk_src(string nm, logic [2:0] e, logic [2:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_src
  task automatic pulse(logic o);
    cmd.out_on = o;
    cmd.out_off = !o;
    tick(1);
    cmd = '0;
  endtask : pulse
  task automatic set_lv(int s, logic b);
    lv[s] = b ? bad_lvl(s, pol) : !bad_lvl(s, pol);
  endtask : set_lv
  task automatic results();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      results();
    end
  end
  initial begin
    tick(2);
    rst_n = 1'h1;
    chk_mode(OIC_MODE_OFF, mode);
    // Functions off, every pin at its forbidding level
    pol = 1'h1;
    lv = 3'h6;
    tick(2);
    pulse(1'h1);
    chk_bit("on", 1'h1, on);
    {pen, pcc} = 6'h0E;
    tick(1);
    chk_mode(OIC_MODE_CV, mode);
    // Random phase masks
    repeat (12) begin
      rnd = lfsr(rnd);
      {pen, pcc} = rnd[5:0];
      tick(1);
      chk_mode(exp_mode(pen, pcc), mode);
    end
    pulse(1'h0);
    chk_mode(OIC_MODE_OFF, mode);
    // Each source, latch off and on, safe then auto start
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      pon = p[0];
      for (int s = 0; s < 3; s++) begin
        for (int l = 0; l < 2; l++) begin
          cfg = '0;
          for (int k = 0; k < 3; k++) set_lv(k, 1'h0);
          cfg[s] = {1'h1, l[0]};
          tick(2);
          pulse(1'h1);
          chk_bit("on", 1'h1, on);
          set_lv(s, 1'h1);
          tick(2);
          chk_bit("inhibit", 1'h0, on);
          chk_bit("blocked", 1'h1, blk[s]);
          chk_bit("shutdown", 1'h1, shd);
          chk_bit("setting", p[0] && !l[0] && s != OIC_SRC_ESTOP, set);
          chk_src("cause", 3'h1 << s, cse);
          if (l) begin
            pulse(1'h1);
            chk_bit("refused", 1'h1, ref_p);
            chk_bit("latched", 1'h1, lat[s]);
          end
          set_lv(s, 1'h0);
          tick(3);
          chk_bit("restore", p[0] && !l[0] && s != OIC_SRC_ESTOP, on);
          pulse(1'h1);
          chk_bit("restart", 1'h1, on);
        end
      end
    end
    // Host off while an auto restore is pending drops the restore
    cfg = '0;
    cfg[OIC_SRC_ILC] = {1'h1, 1'h0};
    tick(2);
    set_lv(OIC_SRC_ILC, 1'h1);
    tick(2);
    chk_bit("setting", 1'h1, set);
    pulse(1'h0);
    set_lv(OIC_SRC_ILC, 1'h0);
    tick(3);
    chk_bit("no restore", 1'h0, on);
    chk_bit("setting", 1'h0, set);
    results();
  end
endmodule : testbench
